// ---- hbt_pkg.sv ----
// Shared constants, types and register map of the break and trace unit
package hbt_pkg;

  // ==========================================================================
  // Sizes
  localparam int NUM_EVENTS = 4;
  localparam int NUM_ACOND = 8;
  localparam int NUM_DCOND = 8;
  localparam int TRACE_DEPTH = 256;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_SEQ = 8'h08;
  localparam logic [7:0] OFS_TRACE_SEL = 8'h0C;
  localparam logic [7:0] OFS_TRACE_W0 = 8'h10;
  localparam logic [7:0] OFS_TRACE_W1 = 8'h14;
  localparam logic [7:0] OFS_TRACE_W2 = 8'h18;
  localparam logic [7:0] OFS_CAUSE = 8'h1C;
  localparam logic [3:0] OFS_EVCFG_PAGE = 4'h2;
  localparam logic [1:0] OFS_ACOND_PAGE = 2'h1;
  localparam logic [1:0] OFS_DCOND_PAGE = 2'h2;

  // ==========================================================================
  // Field positions
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_CLEAR_BIT = 3;
  localparam int CTRL_TRACE_BIT = 4;
  localparam int STAT_OCC_LSB = 0;
  localparam int STAT_BRK_LSB = 4;
  localparam int STAT_SEQ_LSB = 8;
  localparam int STAT_WRAP_BIT = 12;
  localparam int STAT_WIDTH_LSB = 24;
  localparam int TSEL_PTR_LSB = 8;
  localparam int DCOND_MASK_LSB = 16;

  // ==========================================================================
  // Reset values and fixed figures
  localparam logic [31:0] EVCFG_RST = 32'h0000_0000;
  localparam logic [31:0] SEQ_RST = 32'h0000_0000;
  localparam logic [19:0] ADDR_RST = 20'h0_0000;
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [15:0] DMASK_RST = 16'hFFFF;
  localparam logic [7:0] BUS_WIDTH_BITS = 8'h10;
  localparam logic [7:0] PASS_MIN = 8'h01;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int US_NS = 1000;
  localparam logic [5:0] US_TICKS = 6'(US_NS / CLK_PERIOD_NS);

  // ==========================================================================
  // Encodings
  typedef enum logic [2:0] {
    BU_IDLE = 3'h0, BU_NONCPU = 3'h1, BU_INTACK = 3'h2, BU_INSTR_BYTE = 3'h3,
    BU_DATA_BYTE = 3'h4, BU_INSTR_WORD = 3'h5, BU_DATA_WORD = 3'h6
  } hbt_bu_type;

  typedef enum logic [2:0] {
    CS_NONE = 3'h0, CS_OPCODE_BYTE = 3'h1, CS_OPERAND_BYTE = 3'h2,
    CS_QUEUE_FLUSH = 3'h3, CS_OPCODE_WORD = 3'h4, CS_OPERAND_WORD = 3'h5
  } hbt_cs_type;

  typedef enum logic [1:0] {DIR_NONE = 2'h0, DIR_READ = 2'h1, DIR_WRITE = 2'h2} hbt_dir_type;

  typedef enum logic [1:0] {ACC_OFF = 2'h0, ACC_READ = 2'h1, ACC_WRITE = 2'h2, ACC_EITHER = 2'h3} hbt_acc_type;

  typedef enum logic [2:0] {
    KIND_FETCH = 3'h0, KIND_DATA = 3'h1, KIND_BIT = 3'h2, KIND_INTR = 3'h3, KIND_TRIG = 3'h4
  } hbt_kind_type;

  typedef enum logic [1:0] {MODE_ALL = 2'h0, MODE_SAME = 2'h1, MODE_ANY = 2'h2, MODE_SEQ = 2'h3} hbt_mode_type;

  typedef enum logic [1:0] {SEQ_S0 = 2'h0, SEQ_S1 = 2'h1, SEQ_S2 = 2'h3, SEQ_S3 = 2'h2} hbt_seq_type;

  typedef enum logic [1:0] {BRK_IDLE = 2'h0, BRK_PEND = 2'h1, BRK_HALT = 2'h3} hbt_brk_type;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [19:0] addr;
    logic [15:0] data;
    logic high_byte_enable;
    hbt_bu_type bus_unit_status;
    hbt_cs_type cpu_status;
    logic [2:0] queue_fill_count;
    hbt_dir_type dir;
    logic valid_cycle_strobe_n;
  } hbt_bus_type;

  typedef struct packed {
    logic [4:0] pad_hi;
    logic [2:0] probe_sel;
    logic [7:0] pass;
    logic [2:0] pad_lo;
    logic enable;
    logic use_data;
    logic [2:0] dcond;
    logic [2:0] acond;
    hbt_acc_type access;
    hbt_kind_type kind;
  } hbt_evcfg_type;

  typedef struct packed {
    logic [13:0] pad;
    logic [1:0] brk;
    logic [3:0][1:0] nxt;
    logic [3:0][1:0] evsel;
  } hbt_seqcfg_type;

  typedef struct packed {
    logic [2:0] queue_fill_count;
    hbt_cs_type cpu_status;
    hbt_bu_type bus_unit_status;
    logic [19:0] addr;
    hbt_dir_type dir;
    logic high_byte_enable;
    logic [7:0] probes;
    logic [15:0] data;
    logic [31:0] stamp;
  } hbt_trace_type;

endpackage

// ---- hbt_stamp.sv ----
// Microsecond elapsed-time counter for trace entries
`timescale 1ns/10ps
`default_nettype none
module hbt_stamp (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Program state
  input wire logic running,
  // Elapsed time
  output logic [31:0] stamp_us
);
  import hbt_pkg::*;

  logic run_d;
  logic [5:0] pre;
  logic next_run_d;
  logic [5:0] next_pre;
  logic [31:0] next_stamp_us;

  // ==========================================================================
  // Prescaler and count
  always_comb begin
    next_run_d = running;
    next_pre = pre;
    next_stamp_us = stamp_us;
    if (running && !run_d) begin
      // Restart from zero at every program start
      next_pre = 6'h00;
      next_stamp_us = 32'h0000_0000;
    end else if (running) begin
      if (pre == US_TICKS - 6'h01) begin
        next_pre = 6'h00;
        next_stamp_us = stamp_us + 32'h0000_0001;
      end else begin
        next_pre = pre + 6'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      run_d <= 1'b0;
      pre <= 6'h00;
      stamp_us <= 32'h0000_0000;
    end else begin
      run_d <= next_run_d;
      pre <= next_pre;
      stamp_us <= next_stamp_us;
    end
  end

endmodule
`default_nettype wire

// ---- hbt_unit.sv ----
// Hardware break event detection and real-time bus trace unit
//
// Summary of operation
// - Halt only after the breaking instruction completes.
// - Event types: fetch, data, bit, interrupt, trigger.
// - Eight address conditions, single or range.
// - Eight data conditions, single or range.
// - Data events qualify on read, write or either.
// - All mode: every enabled event seen, any order.
// - Same-time mode: all enabled events one cycle.
// - Any mode: break on any enabled event.
// - Sequencer mode: break entering designated break state.
// - Per-event pass count 1 to 255.
// - Same-time mode forces pass count to one.
// - Global enable clear means no break.
// - Trace holds eight probe input levels.
// - Trace holds high byte enable, zero means odd valid.
// - Active-low strobe qualifies address, data, bus status.
// - Bus unit status encodes seven bus activities.
// - CPU status encodes six queue activities.
// - Trace holds prefetch queue fill 0 to 4.
// - Trace holds direction read, write or none.
// - Reported external bus width is 16 bits.
// - Trace timestamp in microseconds since program start.
`timescale 1ns/10ps
`default_nettype none
module hbt_unit (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  // Register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  // Observed processor
  input wire hbt_pkg::hbt_bus_type BUS,
  input wire logic BIT_ACCESS,
  input wire logic INTR_DONE,
  input wire logic INSTR_DONE,
  input wire logic PROG_RUNNING,
  // Probe cable
  input wire logic [7:0] PROBE_IN,
  // Break outputs
  output logic HALT_REQ,
  output logic BREAK_PENDING
);
  import hbt_pkg::*;

  // ==========================================================================
  // Decode and compare helpers
  function automatic logic is_evcfg(input logic [7:0] a);
    return a[7:4] == OFS_EVCFG_PAGE && a[1:0] == 2'h0;
  endfunction

  function automatic logic is_acond(input logic [7:0] a);
    return a[7:6] == OFS_ACOND_PAGE && a[1:0] == 2'h0;
  endfunction

  function automatic logic is_dcond(input logic [7:0] a);
    return a[7:6] == OFS_DCOND_PAGE && a[1:0] == 2'h0;
  endfunction

  function automatic logic addr_hit(input logic [19:0] a, input logic [19:0] lo, input logic [19:0] hi);
    // Single address is lo equal to hi
    return a >= lo && a <= hi;
  endfunction

  function automatic logic data_hit(input logic [15:0] d, input logic [15:0] lo, input logic [15:0] hi,
                                    input logic [15:0] m);
    return (d & m) >= (lo & m) && (d & m) <= (hi & m);
  endfunction

  // ==========================================================================
  // Register state
  logic enable;
  logic trace_on;
  hbt_mode_type mode;
  hbt_evcfg_type evcfg [NUM_EVENTS];
  logic [19:0] alo [NUM_ACOND];
  logic [19:0] ahi [NUM_ACOND];
  logic [15:0] dlo [NUM_DCOND];
  logic [15:0] dhi [NUM_DCOND];
  logic [15:0] dmask [NUM_DCOND];
  hbt_seqcfg_type seqcfg;
  logic [7:0] trace_sel;
  logic next_enable;
  logic next_trace_on;
  hbt_mode_type next_mode;
  hbt_evcfg_type next_evcfg [NUM_EVENTS];
  logic [19:0] next_alo [NUM_ACOND];
  logic [19:0] next_ahi [NUM_ACOND];
  logic [15:0] next_dlo [NUM_DCOND];
  logic [15:0] next_dhi [NUM_DCOND];
  logic [15:0] next_dmask [NUM_DCOND];
  hbt_seqcfg_type next_seqcfg;
  logic [7:0] next_trace_sel;
  logic clr;

  always_comb begin
    next_enable = enable;
    next_trace_on = trace_on;
    next_mode = mode;
    next_evcfg = evcfg;
    next_alo = alo;
    next_ahi = ahi;
    next_dlo = dlo;
    next_dhi = dhi;
    next_dmask = dmask;
    next_seqcfg = seqcfg;
    next_trace_sel = trace_sel;
    clr = REG_WR && REG_ADDR == OFS_CTRL && REG_WDATA[CTRL_CLEAR_BIT];
    if (REG_WR) begin
      if (REG_ADDR == OFS_CTRL) begin
        next_enable = REG_WDATA[CTRL_ENABLE_BIT];
        next_mode = hbt_mode_type'(REG_WDATA[CTRL_MODE_LSB +: 2]);
        next_trace_on = REG_WDATA[CTRL_TRACE_BIT];
      end else if (REG_ADDR == OFS_SEQ) begin
        next_seqcfg = hbt_seqcfg_type'(REG_WDATA);
      end else if (REG_ADDR == OFS_TRACE_SEL) begin
        next_trace_sel = REG_WDATA[7:0];
      end else if (is_evcfg(REG_ADDR)) begin
        next_evcfg[REG_ADDR[3:2]] = hbt_evcfg_type'(REG_WDATA);
      end else if (is_acond(REG_ADDR)) begin
        if (REG_ADDR[2]) begin
          next_ahi[REG_ADDR[5:3]] = REG_WDATA[19:0];
        end else begin
          next_alo[REG_ADDR[5:3]] = REG_WDATA[19:0];
        end
      end else if (is_dcond(REG_ADDR)) begin
        if (REG_ADDR[2]) begin
          next_dhi[REG_ADDR[5:3]] = REG_WDATA[15:0];
        end else begin
          next_dlo[REG_ADDR[5:3]] = REG_WDATA[15:0];
          next_dmask[REG_ADDR[5:3]] = REG_WDATA[DCOND_MASK_LSB +: 16];
        end
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      enable <= 1'b0;
      trace_on <= 1'b0;
      mode <= MODE_ALL;
      for (int i = 0; i < NUM_EVENTS; i++) begin
        evcfg[i] <= hbt_evcfg_type'(EVCFG_RST);
      end
      for (int i = 0; i < NUM_ACOND; i++) begin
        alo[i] <= ADDR_RST;
        ahi[i] <= ADDR_RST;
      end
      for (int i = 0; i < NUM_DCOND; i++) begin
        dlo[i] <= DATA_RST;
        dhi[i] <= DATA_RST;
        dmask[i] <= DMASK_RST;
      end
      seqcfg <= hbt_seqcfg_type'(SEQ_RST);
      trace_sel <= 8'h00;
    end else begin
      enable <= next_enable;
      trace_on <= next_trace_on;
      mode <= next_mode;
      evcfg <= next_evcfg;
      alo <= next_alo;
      ahi <= next_ahi;
      dlo <= next_dlo;
      dhi <= next_dhi;
      dmask <= next_dmask;
      seqcfg <= next_seqcfg;
      trace_sel <= next_trace_sel;
    end
  end

  // ==========================================================================
  // Probe synchroniser, change taken when stages two and three agree
  logic [7:0] probe_s1;
  logic [7:0] probe_s2;
  logic [7:0] probe_s3;
  logic [7:0] probe_lvl;
  logic [7:0] next_probe_lvl;

  always_comb begin
    next_probe_lvl = probe_lvl;
    if (probe_s2 == probe_s3) begin
      next_probe_lvl = probe_s3;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      probe_s1 <= 8'h00;
      probe_s2 <= 8'h00;
      probe_s3 <= 8'h00;
      probe_lvl <= 8'h00;
    end else begin
      probe_s1 <= PROBE_IN;
      probe_s2 <= probe_s1;
      probe_s3 <= probe_s2;
      probe_lvl <= next_probe_lvl;
    end
  end

  // ==========================================================================
  // Event matching and pass counting
  logic [NUM_EVENTS-1:0] match;
  logic [NUM_EVENTS-1:0] fire;
  logic [NUM_EVENTS-1:0] en;
  logic [NUM_EVENTS-1:0] occ;
  logic [NUM_EVENTS-1:0] next_occ;
  logic [7:0] cnt [NUM_EVENTS];
  logic [7:0] next_cnt [NUM_EVENTS];

  always_comb begin
    hbt_evcfg_type c;
    logic valid;
    logic a_ok;
    logic d_ok;
    logic dir_ok;
    logic [7:0] pass_eff;
    c = evcfg[0];
    valid = !BUS.valid_cycle_strobe_n;
    a_ok = 1'b0;
    d_ok = 1'b0;
    dir_ok = 1'b0;
    pass_eff = PASS_MIN;
    for (int i = 0; i < NUM_EVENTS; i++) begin
      c = evcfg[i];
      en[i] = c.enable;
      a_ok = addr_hit(BUS.addr, alo[c.acond], ahi[c.acond]);
      d_ok = !c.use_data || data_hit(BUS.data, dlo[c.dcond], dhi[c.dcond], dmask[c.dcond]);
      dir_ok = (BUS.dir == DIR_READ && (c.access == ACC_READ || c.access == ACC_EITHER))
            || (BUS.dir == DIR_WRITE && (c.access == ACC_WRITE || c.access == ACC_EITHER));
      unique case (c.kind)
        KIND_FETCH: begin
          match[i] = valid && (BUS.bus_unit_status == BU_INSTR_BYTE || BUS.bus_unit_status == BU_INSTR_WORD) && a_ok;
        end
        KIND_DATA: begin
          match[i] = valid && (BUS.bus_unit_status == BU_DATA_BYTE || BUS.bus_unit_status == BU_DATA_WORD
                     || BUS.bus_unit_status == BU_NONCPU) && dir_ok && a_ok && d_ok;
        end
        KIND_BIT: begin
          match[i] = valid && BIT_ACCESS && a_ok;
        end
        KIND_INTR: begin
          match[i] = (valid && BUS.bus_unit_status == BU_INTACK) || INTR_DONE;
        end
        KIND_TRIG: begin
          match[i] = probe_lvl[c.probe_sel];
        end
        default: begin
          match[i] = 1'b0;
        end
      endcase
      match[i] = match[i] && c.enable;
      // Zero pass count behaves as one
      pass_eff = (mode == MODE_SAME || c.pass == 8'h00) ? PASS_MIN : c.pass;
      fire[i] = match[i] && ({1'b0, cnt[i]} + 9'h001 >= {1'b0, pass_eff});
      if (clr) begin
        next_cnt[i] = 8'h00;
      end else if (fire[i]) begin
        next_cnt[i] = 8'h00;
      end else if (match[i]) begin
        next_cnt[i] = cnt[i] + 8'h01;
      end else begin
        next_cnt[i] = cnt[i];
      end
    end
    // Set wins over a clear in the same cycle
    next_occ = (occ & ~{NUM_EVENTS{clr}}) | fire;
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      occ <= '0;
      for (int i = 0; i < NUM_EVENTS; i++) begin
        cnt[i] <= 8'h00;
      end
    end else begin
      occ <= next_occ;
      cnt <= next_cnt;
    end
  end

  // ==========================================================================
  // Combination, sequencer and break control
  hbt_seq_type seq_state;
  hbt_seq_type next_seq_state;
  hbt_brk_type brk_state;
  hbt_brk_type next_brk_state;
  logic [NUM_EVENTS-1:0] cause;
  logic [NUM_EVENTS-1:0] next_cause;
  logic hit;

  always_comb begin
    next_seq_state = seq_state;
    if (clr) begin
      next_seq_state = SEQ_S0;
    end else if (mode == MODE_SEQ && fire[seqcfg.evsel[seq_state]]) begin
      next_seq_state = hbt_seq_type'(seqcfg.nxt[seq_state]);
    end
    unique case (mode)
      MODE_ALL: begin
        hit = (|en) && ((next_occ & en) == en);
      end
      MODE_SAME: begin
        hit = (|en) && ((match & en) == en);
      end
      MODE_ANY: begin
        hit = |fire;
      end
      MODE_SEQ: begin
        // Only entering the break state counts, not sitting in it
        hit = next_seq_state != seq_state && next_seq_state == hbt_seq_type'(seqcfg.brk);
      end
    endcase
    hit = hit && enable;
    next_brk_state = brk_state;
    next_cause = cause;
    unique case (brk_state)
      BRK_IDLE: begin
        if (hit) begin
          next_brk_state = BRK_PEND;
          next_cause = next_occ | fire;
        end
      end
      BRK_PEND: begin
        // Breaking instruction must finish before the halt
        if (!enable || clr) begin
          next_brk_state = BRK_IDLE;
        end else if (INSTR_DONE) begin
          next_brk_state = BRK_HALT;
        end
      end
      BRK_HALT: begin
        if (clr) begin
          next_brk_state = BRK_IDLE;
        end
      end
      default: begin
        next_brk_state = BRK_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      seq_state <= SEQ_S0;
      brk_state <= BRK_IDLE;
      cause <= '0;
    end else begin
      seq_state <= next_seq_state;
      brk_state <= next_brk_state;
      cause <= next_cause;
    end
  end

  assign HALT_REQ = brk_state == BRK_HALT;
  assign BREAK_PENDING = brk_state == BRK_PEND;

  // ==========================================================================
  // Trace capture
  logic [31:0] stamp;
  hbt_trace_type trace_mem [TRACE_DEPTH];
  hbt_trace_type entry;
  logic [7:0] wr_ptr;
  logic [7:0] next_wr_ptr;
  logic wrapped;
  logic next_wrapped;
  logic trace_we;

  hbt_stamp u_stamp (
    .clk(CLK_SYS),
    .reset_n(RESET_N),
    .running(PROG_RUNNING),
    .stamp_us(stamp)
  );

  always_comb begin
    entry.queue_fill_count = BUS.queue_fill_count;
    entry.cpu_status = BUS.cpu_status;
    entry.bus_unit_status = BUS.bus_unit_status;
    entry.addr = BUS.addr;
    entry.dir = BUS.dir;
    entry.high_byte_enable = BUS.high_byte_enable;
    entry.probes = probe_lvl;
    entry.data = BUS.data;
    entry.stamp = stamp;
    trace_we = trace_on && PROG_RUNNING;
    next_wr_ptr = wr_ptr;
    next_wrapped = wrapped;
    if (clr) begin
      next_wr_ptr = 8'h00;
      next_wrapped = trace_we && wr_ptr == 8'hFF;
    end else if (trace_we) begin
      next_wr_ptr = wr_ptr + 8'h01;
      next_wrapped = wrapped || wr_ptr == 8'hFF;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      wr_ptr <= 8'h00;
      wrapped <= 1'b0;
    end else begin
      wr_ptr <= next_wr_ptr;
      wrapped <= next_wrapped;
    end
    if (trace_we) begin
      trace_mem[wr_ptr] <= entry;
    end
  end

  // ==========================================================================
  // Read port, data valid the cycle after the strobe
  logic [31:0] next_rdata;

  always_comb begin
    hbt_trace_type t;
    t = trace_mem[trace_sel];
    next_rdata = 32'h0000_0000;
    if (REG_RD) begin
      if (REG_ADDR == OFS_CTRL) begin
        next_rdata[CTRL_ENABLE_BIT] = enable;
        next_rdata[CTRL_MODE_LSB +: 2] = mode;
        next_rdata[CTRL_TRACE_BIT] = trace_on;
      end else if (REG_ADDR == OFS_STATUS) begin
        next_rdata[STAT_OCC_LSB +: NUM_EVENTS] = occ;
        next_rdata[STAT_BRK_LSB +: 2] = brk_state;
        next_rdata[STAT_SEQ_LSB +: 2] = seq_state;
        next_rdata[STAT_WRAP_BIT] = wrapped;
        next_rdata[STAT_WIDTH_LSB +: 8] = BUS_WIDTH_BITS;
      end else if (REG_ADDR == OFS_SEQ) begin
        next_rdata = seqcfg;
      end else if (REG_ADDR == OFS_TRACE_SEL) begin
        next_rdata[7:0] = trace_sel;
        next_rdata[TSEL_PTR_LSB +: 8] = wr_ptr;
      end else if (REG_ADDR == OFS_TRACE_W0) begin
        next_rdata = {3'h0, t.queue_fill_count, t.cpu_status, t.bus_unit_status, t.addr};
      end else if (REG_ADDR == OFS_TRACE_W1) begin
        next_rdata = {5'h00, t.dir, t.high_byte_enable, t.probes, t.data};
      end else if (REG_ADDR == OFS_TRACE_W2) begin
        next_rdata = t.stamp;
      end else if (REG_ADDR == OFS_CAUSE) begin
        next_rdata[NUM_EVENTS-1:0] = cause;
      end else if (is_evcfg(REG_ADDR)) begin
        next_rdata = evcfg[REG_ADDR[3:2]];
      end else if (is_acond(REG_ADDR)) begin
        next_rdata[19:0] = REG_ADDR[2] ? ahi[REG_ADDR[5:3]] : alo[REG_ADDR[5:3]];
      end else if (is_dcond(REG_ADDR)) begin
        next_rdata = REG_ADDR[2] ? {16'h0000, dhi[REG_ADDR[5:3]]}
                                 : {dmask[REG_ADDR[5:3]], dlo[REG_ADDR[5:3]]};
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      REG_RDATA <= 32'h0000_0000;
    end else begin
      REG_RDATA <= next_rdata;
    end
  end

endmodule
`default_nettype wire

// ---- hbt_cpu_model.sv ----
// Processor core model driving the observed bus
`timescale 1ns/10ps
`default_nettype none
module hbt_cpu (
  // Control
  input wire logic clk,
  input wire logic reset_n,
  input wire logic go,
  input wire hbt_pkg::hbt_bus_type req,
  // Bus side
  output hbt_pkg::hbt_bus_type bus,
  output logic instr_done,
  output logic running
);
  import hbt_pkg::*;
  logic [1:0] cnt;
  // ==========
  // Bus cycles
  always @(posedge clk) begin
    running <= reset_n;
    instr_done <= reset_n && cnt == 2'h1;
    cnt <= !reset_n ? 2'h0 : go ? 2'h3 : cnt - {1'b0, cnt != 2'h0};
    if (!reset_n) bus <= '{20'h0, 16'h0, 1'b1, BU_IDLE, CS_NONE, 3'h0, DIR_NONE, 1'b1};
    else if (go) bus <= req;
    // Released lines toggle so no stale value looks valid
    else bus <= '{~bus.addr, ~bus.data, 1'b1, BU_IDLE, CS_NONE, bus.queue_fill_count, DIR_NONE, 1'b1};
  end
endmodule
`default_nettype wire

// ---- hbt_unit_monitor.sv ----
// Checker for break sequencing and register port timing
`timescale 1ns/10ps
`default_nettype none
module hbt_mon
  import hbt_pkg::*;
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  // Register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [31:0] REG_RDATA,
  // Break side
  input wire logic INSTR_DONE,
  input wire logic HALT_REQ,
  input wire logic BREAK_PENDING
);
  logic en;
  logic next_en;
  // ==========
  // Enable shadow
  always_comb begin
    next_en = RESET_N & ((REG_WR && REG_ADDR == OFS_CTRL) ? REG_WDATA[CTRL_ENABLE_BIT] : en);
  end
  always_ff @(posedge CLK_SYS) begin
    en <= next_en;
  end
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);
  // ==========
  // Properties
  property p_hc; $rose(HALT_REQ) |-> $past(INSTR_DONE) && $past(BREAK_PENDING); endproperty
  a_hc: assert property (p_hc) else $error("halt without completion");
  property p_ex; !(HALT_REQ && BREAK_PENDING); endproperty
  a_ex: assert property (p_ex) else $error("halt and pending together");
  property p_ph; BREAK_PENDING && INSTR_DONE && !REG_WR |=> HALT_REQ && !BREAK_PENDING; endproperty
  a_ph: assert property (p_ph) else $error("pending did not halt");
  property p_hs; HALT_REQ && !REG_WR |=> HALT_REQ; endproperty
  a_hs: assert property (p_hs) else $error("halt dropped");
  property p_en; $rose(BREAK_PENDING) |-> $past(en); endproperty
  a_en: assert property (p_en) else $error("break while disabled");
  property p_wd; REG_RD && REG_ADDR == OFS_STATUS |=> REG_RDATA[31:24] == BUS_WIDTH_BITS; endproperty
  a_wd: assert property (p_wd) else $error("bus width wrong");
  property p_rz; !$past(REG_RD) |-> REG_RDATA == 32'h0; endproperty
  a_rz: assert property (p_rz) else $error("read data without read");
  property p_um; REG_RD && REG_ADDR[1:0] != 2'h0 |=> REG_RDATA == 32'h0; endproperty
  a_um: assert property (p_um) else $error("unmapped read not zero");
endmodule
`default_nettype wire

// ---- tb_hbt_unit.sv ----
// Testbench for the break and trace unit
`timescale 1ns/10ps
`default_nettype none
module tb_hbt_unit;
  import hbt_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, go = 1'b0, rd_d = 1'b0;
  logic [7:0] addr = 8'h00, probes = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [15:0] dat = 16'h0;
  logic [71:0] q;
  logic [71:0] expq[$];
  hbt_bus_type req = '0, bus;
  logic done, running, halt, pend;
  int error_cnt = 0, checks_done = 0, cycles = 0, seed = 32'h3D2C;
  hbt_cpu u_hbt_cpu (.clk(clk), .reset_n(rst_n), .go(go), .req(req), .bus(bus), .instr_done(done),
    .running(running));
  hbt_unit u_hbt_unit (.CLK_SYS(clk), .RESET_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
    .REG_RD(rd), .REG_RDATA(rdata), .BUS(bus), .BIT_ACCESS(1'b0), .INTR_DONE(1'b0), .INSTR_DONE(done),
    .PROG_RUNNING(running), .PROBE_IN(probes), .HALT_REQ(halt), .BREAK_PENDING(pend));
  always #12.5 clk = ~clk;
  // ==========
  // Drivers
  task automatic drv(input logic w, input logic r, input logic g, input logic [7:0] a, input logic [31:0] d);
    wr <= w; rd <= r; go <= g; addr <= a; wdata <= d;
    @(posedge clk);
  endtask
  task automatic wrt(input logic [7:0] a, input logic [31:0] d);
    drv(1'b1, 1'b0, 1'b0, a, d);
  endtask
  task automatic rdx(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    expq.push_back({a, m, e});
    drv(1'b0, 1'b1, 1'b0, a, 32'h0);
  endtask
  task automatic idle;
    repeat (8) drv(1'b0, 1'b0, 1'b0, 8'h00, 32'h0);
  endtask
  task automatic fetch(input logic [19:0] a);
    req <= '{a, dat, 1'b0, BU_INSTR_WORD, CS_OPCODE_WORD, 3'h4, DIR_READ, 1'b0};
    drv(1'b0, 1'b0, 1'b1, 8'h00, 32'h0);
  endtask
  task automatic dacc(input logic [19:0] a, input hbt_dir_type r);
    req <= '{a, dat, 1'b0, BU_DATA_WORD, CS_NONE, 3'h4, r, 1'b0};
    drv(1'b0, 1'b0, 1'b1, 8'h00, 32'h0);
  endtask
  // ==========
  // Checking
  task automatic chk(input logic [7:0] a, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL reg %h expected %h seen %h", a, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (rd_d) begin
      q = expq.pop_front();
      chk(q[71:64], rdata & q[63:32], q[31:0]);
    end
    rd_d <= rd;
    // Whole sequence needs some 140 cycles
    if (cycles == 3000) begin
      error_cnt++;
      wrap_up();
    end
  end
  // ==========
  // Sequence
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    dat = 16'($random(seed));
    probes <= 8'($random(seed));
    rdx(8'h80, 32'hFFFFFFFF, {DMASK_RST, DATA_RST});
    rdx(8'h03, 32'hFFFFFFFF, 32'h0);
    rdx(OFS_STATUS, 32'hFF000000, {BUS_WIDTH_BITS, 24'h0});
    wrt(8'h40, 32'h00100);
    wrt(8'h44, 32'h00110);
    wrt(8'h20, 32'h0001_1000);
    wrt(OFS_CTRL, 32'h1D);
    fetch(20'h00105);
    wrt(OFS_CTRL, 32'h05);
    idle();
    chk(8'hFF, {30'h0, halt, pend}, 32'h2);
    rdx(OFS_STATUS, 32'h30, 32'h30);
    rdx(OFS_TRACE_SEL, 32'hFF00, 32'h0200);
    wrt(OFS_TRACE_SEL, 32'h01);
    rdx(OFS_TRACE_W0, 32'hFFFFFFFF, {3'h0, 3'h4, CS_OPCODE_WORD, BU_INSTR_WORD, 20'h00105});
    rdx(OFS_TRACE_W1, 32'hFFFFFFFF, {5'h0, DIR_READ, 1'b0, probes, dat});
    rdx(OFS_TRACE_W2, 32'hFFFFFFFF, 32'h0);
    $display("any mode and trace done");
    wrt(OFS_CTRL, 32'h0C);
    fetch(20'h00100);
    idle();
    rdx(OFS_STATUS, 32'h30, 32'h0);
    $display("disabled break done");
    wrt(8'h20, 32'h0003_1000);
    wrt(OFS_CTRL, 32'h0D);
    fetch(20'h00111);
    fetch(20'h00110);
    fetch(20'h00100);
    idle();
    rdx(OFS_STATUS, 32'h30, 32'h0);
    fetch(20'h00110);
    idle();
    rdx(OFS_STATUS, 32'h30, 32'h30);
    $display("pass count done");
    wrt(OFS_CTRL, 32'h0B);
    fetch(20'h00108);
    idle();
    rdx(OFS_STATUS, 32'h31, 32'h31);
    idle();
    $display("same time mode done");
    wrt(8'h20, 32'h0001_1000);
    wrt(8'h80, 32'hFF00_5400);
    wrt(8'h84, 32'h5400);
    wrt(8'h24, 32'h0001_1811);
    wrt(OFS_CTRL, 32'h09);
    fetch(20'h00108);
    dat = {8'h54, 8'($random(seed))};
    dacc(20'h00104, DIR_READ);
    dat[15:8] = 8'h55;
    dacc(20'h00104, DIR_WRITE);
    dat[15:8] = 8'h54;
    idle();
    rdx(OFS_STATUS, 32'h33, 32'h01);
    dacc(20'h00104, DIR_WRITE);
    idle();
    rdx(OFS_STATUS, 32'h33, 32'h33);
    $display("all mode done");
    wrt(OFS_SEQ, 32'h0003_0D04);
    wrt(OFS_CTRL, 32'h0F);
    dacc(20'h00104, DIR_WRITE);
    fetch(20'h00108);
    idle();
    rdx(OFS_STATUS, 32'h330, 32'h100);
    dacc(20'h00104, DIR_WRITE);
    idle();
    rdx(OFS_STATUS, 32'h330, 32'h330);
    idle();
    $display("sequencer mode done");
    wrap_up();
  end
endmodule
bind hbt_unit hbt_mon u_hbt_mon (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .INSTR_DONE(INSTR_DONE),
  .HALT_REQ(HALT_REQ), .BREAK_PENDING(BREAK_PENDING));
`default_nettype wire
